// ===== hw/cfa_scan_frame.sv
// Purpose: Assembles one instrument scan into a gap-free byte frame for the host.
// Assumes: Scan fields arrive with scan_valid on ref_clk; status pins are asynchronous.
// Notes:   Settings are latched at scan start so a register write never splits a frame.
//
// Notes on behaviour
// - Two voltage channels fill three bytes: high, split nibbles, low.
// - Light value follows a zero byte: high nibble low, then eight low bits.
// - Light count rises with voltage; passed through as sampled.
// - Pressure temperature high byte, then its low nibble over status nibble.
// - Pressure temperature is sent as a plain unsigned twelve-bit code.
// - Status bit zero is one while the pump runs.
// - Status bit one is one while the bottom switch is open.
// - Status bit two is one while the sampler confirm is seen.
// - Status bit three is zero while modem carrier is detected.
// - Eight-bit modulo count advances each scan and wraps to zero.
// - With averaging the modulo count advances by the averaged scan count.
// - End-of-frame marker is raised with the modulo count byte only.
// - Dropping secondary sensors removes words three and four.
// - Fewer voltage words drops words eight downward toward five.
// - Unused light channel removes word nine.
// - Remaining bytes are packed without gaps.
// - Voltage channels are sent inverted: full code at zero volts.
//
// Local design decisions: the address map and register access over APB.
`default_nettype none

module cfa_scan_frame
  import cfa_pkg::*;
#(
  parameter int unsigned NAV_BYTES = 16,
  parameter int unsigned AW        = 6
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  input  wire logic [11:0]                     paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            scan_valid,
  output logic                                 scan_ready,
  input  wire logic [FREQ_WORDS*FREQ_W-1:0]    freq_words,
  input  wire logic [VOLT_CH*SAMPLE_W-1:0]     volt_adc,
  input  wire logic [SAMPLE_W-1:0]             light_adc,
  input  wire logic [SAMPLE_W-1:0]             ptemp_code,
  input  wire logic [NAV_BYTES*8-1:0]          nav_data,
  input  wire logic                            pump_run,
  input  wire logic                            bottom_closed,
  input  wire logic                            sampler_confirm,
  input  wire logic                            carrier_det,
  output logic      [7:0]                      out_data,
  output logic                                 out_valid,
  output logic                                 out_eoi,
  input  wire logic                            out_ready
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    cfa_state_t                       fsm;
    logic [3:0]                       sync1;
    logic [3:0]                       sync2;
    logic                             cfg_drop_sec;
    logic                             cfg_light_en;
    logic                             cfg_nav_en;
    logic [2:0]                       cfg_vwords;
    logic [7:0]                       cfg_avg;
    logic                             f_drop_sec;
    logic                             f_light_en;
    logic                             f_nav_en;
    logic [2:0]                       f_vwords;
    logic [7:0]                       f_avg;
    logic [FREQ_WORDS*FREQ_W-1:0]     f_freq;
    logic [VOLT_CH*SAMPLE_W-1:0]      f_volt;
    logic [SAMPLE_W-1:0]              f_light;
    logic [SAMPLE_W-1:0]              f_ptemp;
    logic [3:0]                       f_stat;
    logic [NAV_BYTES*8-1:0]           f_nav;
    logic [5:0]                       slot;
    logic [AW-1:0]                    wptr;
    logic [AW-1:0]                    rptr;
    logic [AW-1:0]                    len;
    logic [AW-1:0]                    mod_pos;
    logic [7:0]                       modulo;
    logic [15:0]                      scans;
    logic                             pready;
    logic                             pslverr;
    logic [31:0]                      prdata;
    logic                             scan_ready;
    logic [7:0]                       out_data;
    logic                             out_valid;
    logic                             out_eoi;
  } cfa_st_t;

  cfa_st_t st_ff;
  cfa_st_t nxt_st;

  cfa_mem_if #(.AW(AW)) mem_port ();

  localparam logic [5:0] SLOT_LAST_NAV = 6'(FULL_SLOTS + NAV_BYTES - 1);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    return (a == OFS_CTRL) || (a == OFS_AVG) || (a == OFS_STAT) || (a == OFS_SCANS);
  endfunction

  // Decides whether a slot of the full frame survives the suppression settings.
  function automatic logic slot_kept(input logic [5:0] s, input logic drop_sec,
                                     input logic [2:0] vw, input logic light_en);
    logic [5:0] w;
    logic       keep;
    w    = s / BYTES_PER_WORD;
    keep = 1'b1;
    if ((w == WORD_SEC_T) || (w == WORD_SEC_C)) begin
      keep = !drop_sec;
    end else if ((w >= WORD_VOLT0) && (w <= WORD_VOLT3)) begin
      keep = (w - WORD_VOLT0) < {3'h0, vw};
    end else if (w == WORD_LIGHT) begin
      keep = light_en;
    end
    return keep;
  endfunction

  // Produces byte s of the unsuppressed frame from the latched scan fields.
  function automatic logic [7:0] frame_byte(input cfa_st_t f, input logic [5:0] s);
    logic [5:0]          w;
    logic [5:0]          r;
    logic [2:0]          k;
    logic [SAMPLE_W-1:0] ch_a;
    logic [SAMPLE_W-1:0] ch_b;
    logic [FREQ_W-1:0]   fq;
    logic [7:0]          b;
    w    = s / BYTES_PER_WORD;
    r    = s - (w * BYTES_PER_WORD);
    k    = 3'(w - WORD_VOLT0);
    ch_a = ~f.f_volt[{k, 1'b0} * SAMPLE_W +: SAMPLE_W];
    ch_b = ~f.f_volt[{k, 1'b1} * SAMPLE_W +: SAMPLE_W];
    fq   = f.f_freq[w[2:0] * FREQ_W +: FREQ_W];
    b    = 8'h00;
    if (w < WORD_VOLT0) begin
      b = (r == 6'h00) ? fq[23:16] : (r == 6'h01) ? fq[15:8] : fq[7:0];
    end else if (w <= WORD_VOLT3) begin
      b = (r == 6'h00) ? ch_a[11:4] : (r == 6'h01) ? {ch_a[3:0], ch_b[11:8]} : ch_b[7:0];
    end else if (w == WORD_LIGHT) begin
      b = (r == 6'h00) ? 8'h00 : (r == 6'h01) ? {4'h0, f.f_light[11:8]} : f.f_light[7:0];
    end else if (w == WORD_PTEMP) begin
      b = (r == 6'h00) ? f.f_ptemp[11:4] : (r == 6'h01) ? {f.f_ptemp[3:0], f.f_stat} :
          f.modulo;
    end
    return b;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic       acc;
    logic       wr;
    logic [7:0] step;
    logic [3:0] stat;
    acc    = 1'b0;
    wr     = 1'b0;
    step   = 8'h00;
    stat   = 4'h0;
    nxt_st = st_ff;

    nxt_st.sync1 = {carrier_det, sampler_confirm, bottom_closed, pump_run};
    nxt_st.sync2 = st_ff.sync1;
    stat[ST_PUMP]      = st_ff.sync2[0];
    stat[ST_BOTTOM]    = !st_ff.sync2[1];
    stat[ST_CONFIRM]   = st_ff.sync2[2];
    stat[ST_NOCARRIER] = !st_ff.sync2[3];

    // APB: one wait state, answer registered on the second access cycle.
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    if (psel && penable && !st_ff.pready) begin
      nxt_st.pready  = 1'b1;
      nxt_st.pslverr = !is_mapped(paddr);
      unique case (paddr)
        OFS_CTRL:  nxt_st.prdata = {25'h0, st_ff.cfg_vwords, 1'b0, st_ff.cfg_nav_en,
                                    st_ff.cfg_light_en, st_ff.cfg_drop_sec};
        OFS_AVG:   nxt_st.prdata = {24'h0, st_ff.cfg_avg};
        OFS_STAT:  nxt_st.prdata = {8'h00, 2'(0), 6'(st_ff.len), st_ff.modulo, 3'h0,
                                    !st_ff.fsm[0], stat};
        OFS_SCANS: nxt_st.prdata = {16'h0000, st_ff.scans};
        default:   nxt_st.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && st_ff.pready && pwrite && is_mapped(paddr)) begin
      if (paddr == OFS_CTRL) begin
        nxt_st.cfg_drop_sec = pwdata[CTRL_DROP_SEC];
        nxt_st.cfg_light_en = pwdata[CTRL_LIGHT_EN];
        nxt_st.cfg_nav_en   = pwdata[CTRL_NAV_EN];
        nxt_st.cfg_vwords   = (pwdata[CTRL_VW_LSB +: CTRL_VW_W] > VW_MAX) ? VW_MAX :
                              pwdata[CTRL_VW_LSB +: CTRL_VW_W];
      end else if (paddr == OFS_AVG) begin
        nxt_st.cfg_avg = pwdata[7:0];
      end
    end

    unique case (st_ff.fsm)
      CFA_IDLE: begin
        acc = scan_valid && st_ff.scan_ready;
        if (acc) begin
          nxt_st.scan_ready = 1'b0;
          nxt_st.f_drop_sec = st_ff.cfg_drop_sec;
          nxt_st.f_light_en = st_ff.cfg_light_en;
          nxt_st.f_nav_en   = st_ff.cfg_nav_en;
          nxt_st.f_vwords   = st_ff.cfg_vwords;
          nxt_st.f_avg      = st_ff.cfg_avg;
          nxt_st.f_freq     = freq_words;
          nxt_st.f_volt     = volt_adc;
          nxt_st.f_light    = light_adc;
          nxt_st.f_ptemp    = ptemp_code;
          nxt_st.f_stat     = stat;
          nxt_st.f_nav      = nav_data;
          nxt_st.slot       = 6'h00;
          nxt_st.wptr       = '0;
          nxt_st.fsm        = CFA_BUILD;
        end
      end
      CFA_BUILD: begin
        if (st_ff.slot < SLOT_NAV) begin
          wr = slot_kept(st_ff.slot, st_ff.f_drop_sec, st_ff.f_vwords, st_ff.f_light_en);
        end else begin
          wr = st_ff.f_nav_en;
        end
        if (wr) begin
          nxt_st.wptr = st_ff.wptr + 1'b1;
        end
        if (st_ff.slot == SLOT_MOD) begin
          nxt_st.mod_pos = st_ff.wptr;
        end
        nxt_st.slot = st_ff.slot + 6'h01;
        if ((st_ff.slot == SLOT_MOD && !st_ff.f_nav_en) || st_ff.slot == SLOT_LAST_NAV) begin
          step = (st_ff.f_avg == 8'h00) ? 8'h01 : st_ff.f_avg;
          nxt_st.modulo = st_ff.modulo + step;
          nxt_st.scans  = st_ff.scans + 16'h0001;
          nxt_st.len    = nxt_st.wptr;
          nxt_st.rptr   = '0;
          nxt_st.fsm    = CFA_FETCH;
        end
      end
      CFA_FETCH: begin
        nxt_st.fsm = CFA_LOAD;
      end
      CFA_LOAD: begin
        nxt_st.out_data  = mem_port.rd_data;
        nxt_st.out_eoi   = (st_ff.rptr == st_ff.mod_pos);
        nxt_st.out_valid = 1'b1;
        nxt_st.fsm       = CFA_SEND;
      end
      CFA_SEND: begin
        if (out_ready) begin
          nxt_st.out_valid = 1'b0;
          nxt_st.out_eoi   = 1'b0;
          if (st_ff.rptr == st_ff.len - 1'b1) begin
            nxt_st.scan_ready = 1'b1;
            nxt_st.fsm        = CFA_IDLE;
          end else begin
            nxt_st.rptr = st_ff.rptr + 1'b1;
            nxt_st.fsm  = CFA_FETCH;
          end
        end
      end
      default: begin
        nxt_st.fsm = CFA_IDLE;
      end
    endcase

    mem_port.wr_en   = wr;
    mem_port.wr_addr = st_ff.wptr;
    mem_port.wr_data = (st_ff.slot < SLOT_NAV) ? frame_byte(st_ff, st_ff.slot) :
                       st_ff.f_nav[6'(st_ff.slot - SLOT_NAV) * 8 +: 8];
    mem_port.rd_addr = st_ff.rptr;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff              <= '0;
      st_ff.fsm          <= CFA_IDLE;
      st_ff.cfg_drop_sec <= RST_DROP_SEC;
      st_ff.cfg_light_en <= RST_LIGHT_EN;
      st_ff.cfg_nav_en   <= RST_NAV_EN;
      st_ff.cfg_vwords   <= RST_VWORDS;
      st_ff.cfg_avg      <= RST_AVG;
      st_ff.scan_ready   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  cfa_frame_mem #(.AW(AW)) u_mem (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .port    (mem_port.mem)
  );

  assign prdata     = st_ff.prdata;
  assign pready     = st_ff.pready;
  assign pslverr    = st_ff.pslverr;
  assign scan_ready = st_ff.scan_ready;
  assign out_data   = st_ff.out_data;
  assign out_valid  = st_ff.out_valid;
  assign out_eoi    = st_ff.out_eoi;

endmodule

`default_nettype wire

// ===== hw/cfa_pkg.sv
// Purpose: Constants shared by the scan frame assembler and its test bench.
// Assumes: One 250 MHz clock, APB register access with 32-bit data.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
`default_nettype none

package cfa_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int unsigned FREQ_WORDS   = 5;
  localparam int unsigned FREQ_W       = 24;
  localparam int unsigned VOLT_CH      = 8;
  localparam int unsigned SAMPLE_W     = 12;
  localparam int unsigned FULL_SLOTS   = 33;
  localparam logic [5:0]  SLOT_MOD     = 6'h20;
  localparam logic [5:0]  SLOT_NAV     = 6'h21;
  localparam logic [5:0]  WORD_SEC_T   = 6'h03;
  localparam logic [5:0]  WORD_SEC_C   = 6'h04;
  localparam logic [5:0]  WORD_VOLT0   = 6'h05;
  localparam logic [5:0]  WORD_VOLT3   = 6'h08;
  localparam logic [5:0]  WORD_LIGHT   = 6'h09;
  localparam logic [5:0]  WORD_PTEMP   = 6'h0A;
  localparam logic [5:0]  BYTES_PER_WORD = 6'h03;

  // ----------------------------------------------------------------------
  // Status nibble bit positions
  // ----------------------------------------------------------------------
  localparam int unsigned ST_PUMP      = 0;
  localparam int unsigned ST_BOTTOM    = 1;
  localparam int unsigned ST_CONFIRM   = 2;
  localparam int unsigned ST_NOCARRIER = 3;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_AVG      = 12'h004;
  localparam logic [11:0] OFS_STAT     = 12'h008;
  localparam logic [11:0] OFS_SCANS    = 12'h00C;

  localparam int unsigned CTRL_DROP_SEC = 0;
  localparam int unsigned CTRL_LIGHT_EN = 1;
  localparam int unsigned CTRL_NAV_EN   = 2;
  localparam int unsigned CTRL_VW_LSB   = 4;
  localparam int unsigned CTRL_VW_W     = 3;
  localparam logic [2:0]  VW_MAX        = 3'h4;

  localparam logic        RST_DROP_SEC = 1'b0;
  localparam logic        RST_LIGHT_EN = 1'b1;
  localparam logic        RST_NAV_EN   = 1'b0;
  localparam logic [2:0]  RST_VWORDS   = 3'h4;
  localparam logic [7:0]  RST_AVG      = 8'h01;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    CFA_IDLE  = 5'b00001,
    CFA_BUILD = 5'b00010,
    CFA_FETCH = 5'b00100,
    CFA_LOAD  = 5'b01000,
    CFA_SEND  = 5'b10000
  } cfa_state_t;

endpackage

`default_nettype wire

// ===== hw/cfa_mem_if.sv
// Purpose: Write and read port bundle between the assembler and its frame memory.
// Assumes: Both ends sit on ref_clk.
// Notes:   Read data appear one clock after the address.
`default_nettype none

interface cfa_mem_if #(
  parameter int unsigned AW = 6
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0]    wr_data;
  logic [AW-1:0] rd_addr;
  logic [7:0]    rd_data;

  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

`default_nettype wire

// ===== hw/cfa_frame_mem.sv
// Purpose: Byte store holding one compacted scan frame.
// Assumes: Single clock; one write and one read per cycle.
// Notes:   The array itself has no reset; only the read register does.
`default_nettype none

module cfa_frame_mem #(
  parameter int unsigned AW = 6
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  cfa_mem_if.mem    port
);

  logic [7:0] mem_q [2**AW];
  logic [7:0] rd_data_ff;

  always_ff @(posedge ref_clk) begin
    if (port.wr_en) begin
      mem_q[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= mem_q[port.rd_addr];
    end
  end

  assign port.rd_data = rd_data_ff;

endmodule

`default_nettype wire

// ===== sim/cfa_scan_frame_properties.sv
// Purpose: Port-level timing checks for the scan frame assembler.
// Assumes: Single ref_clk domain, rst_n asynchronous active low.
// Notes:   Byte spacing and APB latency are the block's own fixed timing.
`default_nettype none

module cfa_frame_checker (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pready,
  input  wire logic       pslverr,
  input  wire logic       scan_valid,
  input  wire logic       scan_ready,
  input  wire logic [7:0] out_data,
  input  wire logic       out_valid,
  input  wire logic       out_eoi,
  input  wire logic       out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------
  sequence seq_accept;
    out_valid && out_ready;
  endsequence
  sequence seq_gap;
    !out_valid [*2];
  endsequence
  sequence seq_stall;
    out_valid && !out_ready;
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_EOI_WITH_VALID: assert property (out_eoi |-> out_valid)
    else $error("end marker without a valid byte");
  AST_BYTE_HOLD: assert property (
    seq_stall |=> out_valid && $stable(out_data) && $stable(out_eoi))
    else $error("byte changed before acceptance");
  AST_EOI_SINGLE: assert property (seq_accept and out_eoi |=> !out_eoi)
    else $error("end marker repeated");
  AST_BYTE_GAP: assert property (seq_accept |=> seq_gap)
    else $error("next byte offered too early");
  AST_OUT_BUSY: assert property (out_valid |-> !scan_ready)
    else $error("byte offered while idle");
  AST_SCAN_TAKE: assert property (scan_valid && scan_ready |=> !scan_ready)
    else $error("scan accepted but still ready");
  AST_APB_LAT: assert property (psel && $rose(penable) |=> pready)
    else $error("apb answer not one cycle into access");
  AST_APB_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule

bind cfa_scan_frame cfa_frame_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .scan_valid(scan_valid), .scan_ready(scan_ready), .out_data(out_data),
  .out_valid(out_valid), .out_eoi(out_eoi), .out_ready(out_ready)
);

`default_nettype wire

// ===== sim/cfa_host_model.sv
// Purpose: Host that reads frame bytes and records them.
// Assumes: Byte taken on an edge with out_valid and out_ready.
// Notes:   Slow mode toggles ready each cycle to stall the sender.
`default_nettype none

module cfa_host_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       slow,
  input  wire logic       clr,
  input  wire logic [7:0] out_data,
  input  wire logic       out_valid,
  input  wire logic       out_eoi,
  output logic            out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [0:63];
  int         n;
  int         eoi_at;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ready <= 1'b0;
      n         <= 0;
      eoi_at    <= -1;
    end else begin
      out_ready <= slow ? ~out_ready : 1'b1;
      if (clr) begin
        n      <= 0;
        eoi_at <= -1;
      end else if (out_valid && out_ready) begin
        got[n[5:0]] <= out_data;
        n           <= n + 1;
        if (out_eoi) eoi_at <= n;
      end
    end
  end
endmodule

`default_nettype wire

// ===== sim/ctd_scan_frame_assembler_test.sv
// Purpose: Self-checking bench for the scan frame assembler.
// Assumes: APB access with one wait state; bytes taken on valid and ready.
// Notes:   Expected frames are rebuilt here from the field layout.
`default_nettype none

module ctd_scan_frame_assembler_test;
  import cfa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, scan_valid, scan_ready;
  logic pump_run, bottom_closed, sampler_confirm, carrier_det, out_valid, out_eoi, out_ready;
  logic host_slow, host_clr;
  logic [11:0]  paddr, light_adc, ptemp_code;
  logic [31:0]  pwdata, prdata, rd;
  logic [7:0]   out_data, exp_mod;
  logic [119:0] freq_words;
  logic [95:0]  volt_adc;
  logic [127:0] nav_data;
  logic         c_drop, c_light, c_nav, err;
  logic [2:0]   c_vw;
  logic [7:0]   c_avg;
  int           miscompares, num_checks, cycles;

  cfa_scan_frame #(.NAV_BYTES(16), .AW(6)) dut (.*);
  cfa_host_model u_host (.ref_clk(ref_clk), .rst_n(rst_n), .slow(host_slow), .clr(host_clr),
    .out_data(out_data), .out_valid(out_valid), .out_eoi(out_eoi), .out_ready(out_ready));

  // ----------------------------------------------------------------------
  // Clock, reset, timeout
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------------
  // APB master: one idle edge after each transfer
  // ----------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n == 50) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic setcfg(input logic dr, input logic li, input logic nv, input logic [2:0] vw,
                        input logic [7:0] av);
    {c_drop, c_light, c_nav, c_vw, c_avg} = {dr, li, nv, vw, av};
    apb(1'b1, OFS_CTRL, {25'h0, vw, 1'b0, nv, li, dr});
    apb(1'b1, OFS_AVG, {24'h0, av});
  endtask

  // ----------------------------------------------------------------------
  // One scan: drive fields, build expected frame, compare
  // ----------------------------------------------------------------------
  task automatic scan(input logic [3:0] pins, input logic [7:0] k);
    logic [7:0]  s [0:32];
    logic [11:0] a, b;
    logic [3:0]  st;
    logic [7:0]  q [$];
    int          n;
    for (int i = 0; i < 15; i++) freq_words[i*8 +: 8] <= k + 8'(i);
    for (int i = 0; i < 8; i++) volt_adc[i*12 +: 12] <= {k ^ 8'(i*37), 4'(i + 3)};
    for (int i = 0; i < 16; i++) nav_data[i*8 +: 8] <= 8'hA0 + 8'(i);
    light_adc <= {4'h9, k};
    ptemp_code <= {k, 4'hC};
    {carrier_det, sampler_confirm, bottom_closed, pump_run} <= pins;
    host_clr <= 1'b1;
    repeat (4) @(posedge ref_clk);
    host_clr <= 1'b0;
    scan_valid <= 1'b1;
    @(posedge ref_clk);
    scan_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (scan_ready !== 1'b1 && n < 2000);
    for (int w = 0; w < 15; w++) s[w] = freq_words[(w/3)*24 + 16 - (w%3)*8 +: 8];
    for (int p = 0; p < 4; p++) begin
      a = ~volt_adc[24*p +: 12];
      b = ~volt_adc[24*p + 12 +: 12];
      s[15+3*p] = a[11:4];
      s[16+3*p] = {a[3:0], b[11:8]};
      s[17+3*p] = b[7:0];
    end
    st = {~pins[3], pins[2], ~pins[1], pins[0]};
    {s[27], s[28], s[29]} = {8'h00, 4'h0, light_adc};
    {s[30], s[31], s[32]} = {ptemp_code, st, exp_mod};
    for (int w = 0; w < 11; w++)
      if (w < 3 || w == 10 || ((w == 3 || w == 4) && !c_drop) || (w >= 5 && w <= 8 && w - 5 < c_vw)
          || (w == 9 && c_light))
        for (int j = 0; j < 3; j++) q.push_back(s[3*w+j]);
    for (int i = 0; i < 16; i++) if (c_nav) q.push_back(nav_data[i*8 +: 8]);
    chk(u_host.n, q.size());
    for (int i = 0; i < q.size(); i++) chk(u_host.got[i], q[i]);
    chk(u_host.eoi_at, q.size() - 1 - (c_nav ? 16 : 0));
    exp_mod = exp_mod + ((c_avg == 8'h00) ? 8'h01 : c_avg);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, scan_valid, host_slow, host_clr} = '0;
    {pump_run, bottom_closed, sampler_confirm, carrier_det} = '0;
    {paddr, pwdata, freq_words, volt_adc, nav_data, light_adc, ptemp_code} = '0;
    {miscompares, num_checks, cycles} = '0;
    {c_drop, c_light, c_nav, c_vw, c_avg, exp_mod} = {1'b0, 1'b1, 1'b0, 3'h4, 8'h01, 8'h00};
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, {25'h0, RST_VWORDS, 1'b0, RST_NAV_EN, RST_LIGHT_EN, RST_DROP_SEC});
    apb(1'b0, OFS_AVG, 32'h0);
    chk(rd, 32'h00000001);
    apb(1'b0, 12'h010, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    scan(4'b0000, 8'h10);
    setcfg(1'b1, 1'b0, 1'b0, 3'h0, 8'h01);
    scan(4'b1111, 8'h5A);
    for (int v = 1; v < 4; v++) begin
      host_slow <= v[0];
      setcfg(1'b0, 1'b1, v == 2, 3'(v), 8'(v));
      scan(4'(v * 5), 8'(v * 33));
    end
    host_slow <= 1'b0;
    setcfg(1'b0, 1'b1, 1'b1, 3'h4, 8'hF0);
    scan(4'b0101, 8'hE1);
    scan(4'b1010, 8'h3C);
    setcfg(1'b1, 1'b1, 1'b0, 3'h2, 8'h00);
    scan(4'b0110, 8'h77);
    apb(1'b0, OFS_SCANS, 32'h0);
    chk(rd, 32'h00000008);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd[21:0], {6'h15, exp_mod, 8'h0C});
    end_sim();
  end
endmodule

`default_nettype wire
